// ### rtl/rtcc_defines.vh
// Offsets, field positions, reset values and timing counts of the clock control block
`ifndef RTCC_DEFINES_VH
`define RTCC_DEFINES_VH
// Register indices; byte address is four times the index
`define RTCC_IDX_SEC 8'h00
`define RTCC_IDX_SEC_ALM 8'h01
`define RTCC_IDX_MIN 8'h02
`define RTCC_IDX_MIN_ALM 8'h03
`define RTCC_IDX_HOUR 8'h04
`define RTCC_IDX_HOUR_ALM 8'h05
`define RTCC_IDX_DOW 8'h06
`define RTCC_IDX_DOM 8'h07
`define RTCC_IDX_MON 8'h08
`define RTCC_IDX_YEAR 8'h09
`define RTCC_IDX_RATE 8'h0A
`define RTCC_IDX_MODE 8'h0B
`define RTCC_IDX_FLAGS 8'h0C
`define RTCC_IDX_VALID 8'h0D
`define RTCC_IDX_CENT 8'h32
`define RTCC_IDX_SHR0 8'h7F
`define RTCC_IDX_SHR1 8'hFF
// Mode register fields
`define RTCC_MODE_SET 7
`define RTCC_MODE_PIE 6
`define RTCC_MODE_AIE 5
`define RTCC_MODE_UIE 4
`define RTCC_MODE_BIN 2
`define RTCC_MODE_H24 1
// Valid register fields
`define RTCC_VALID_VRT 7
// Reset values
`define RTCC_DV_BAT_RST 3'h3
`define RTCC_SHR_RST 8'h80
`define RTCC_DIV_RST 22'h004000
// Divider control codes
`define RTCC_DV_OSC_OFF 3'h3
// Timing
`define RTCC_OSC_HZ 32768
`define RTCC_CLK_KHZ 25000
`define RTCC_UIP_LEAD_US 244
`define RTCC_UPD_US 1948
`define RTCC_UIP_LEAD_TICKS ((`RTCC_UIP_LEAD_US * `RTCC_OSC_HZ + 999999) / 1000000)
`define RTCC_UPD_CYC ((`RTCC_UPD_US * `RTCC_CLK_KHZ) / 1000)
// Bus responses
`define RTCC_RESP_OKAY 2'h0
`define RTCC_RESP_SLVERR 2'h2
`endif

// ### rtl/rtcc_cal.v
// Time and calendar counters stepping in binary or BCD, 12 or 24 hour
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_defines.vh"
module rtcc_cal (
    // Clock, battery reset, enable
    input wire i_clk,
    input wire i_bat_rst_n,
    input wire i_ce,
    // Load port
    input wire i_wr,
    input wire [7:0] i_idx,
    input wire [7:0] i_wdata,
    // Update control
    input wire i_step,
    input wire i_bin,
    input wire i_h24,
    // Counter bytes
    output reg [7:0] o_sec,
    output reg [7:0] o_min,
    output reg [7:0] o_hour,
    output reg [7:0] o_dow,
    output reg [7:0] o_dom,
    output reg [7:0] o_mon,
    output reg [7:0] o_year,
    output reg [7:0] o_cent
);
    function [7:0] dec;
        input [7:0] v;
        input bin;
        dec = bin ? v : ({4'h0, v[7:4]} * 8'h0A + {4'h0, v[3:0]});
    endfunction
    function [7:0] enc;
        input [7:0] b;
        input bin;
        enc = bin ? b : (((b / 8'h0A) << 4) | (b % 8'h0A));
    endfunction
    // Carry in bit 8; out-of-range values wrap too
    function [8:0] inc;
        input [7:0] v;
        input [7:0] lo;
        input [7:0] hi;
        input bin;
        if (dec(v, bin) >= hi)
            inc = {1'b1, enc(lo, bin)};
        else
            inc = {1'b0, enc(dec(v, bin) + 8'h01, bin)};
    endfunction
    function [7:0] mdays;
        input [7:0] m;
        input [7:0] y;
        case (m)
            8'h02: mdays = (y[1:0] == 2'h0) ? 8'h1D : 8'h1C;
            8'h04, 8'h06, 8'h09, 8'h0B: mdays = 8'h1E;
            default: mdays = 8'h1F;
        endcase
    endfunction

    reg [8:0] s_nxt, mi_nxt, h_nxt, w_nxt, d_nxt, mo_nxt, y_nxt, c_nxt;
    reg [7:0] hv, he;
    always @* begin
        s_nxt = inc(o_sec, 8'h00, 8'h3B, i_bin);
        mi_nxt = inc(o_min, 8'h00, 8'h3B, i_bin);
        hv = dec({1'b0, o_hour[6:0]}, i_bin);
        he = enc((hv >= 8'h0C) ? 8'h01 : hv + 8'h01, i_bin);
        if (i_h24)
            h_nxt = inc(o_hour, 8'h00, 8'h17, i_bin);
        else if (hv >= 8'h0C)
            h_nxt = {1'b0, o_hour[7], he[6:0]};
        else if (hv == 8'h0B)
            h_nxt = {o_hour[7], ~o_hour[7], he[6:0]};
        else
            h_nxt = {1'b0, o_hour[7], he[6:0]};
        w_nxt = inc(o_dow, 8'h01, 8'h07, i_bin);
        d_nxt = inc(o_dom, 8'h01, mdays(dec(o_mon, i_bin), dec(o_year, i_bin)), i_bin);
        mo_nxt = inc(o_mon, 8'h01, 8'h0C, i_bin);
        y_nxt = inc(o_year, 8'h00, 8'h63, i_bin);
        c_nxt = inc(o_cent, 8'h00, 8'h63, i_bin);
    end

    // A step outranks a load in the same cycle
    always @(posedge i_clk) begin
        if (!i_bat_rst_n) begin
            o_sec <= 8'h00;
            o_min <= 8'h00;
            o_hour <= 8'h00;
            o_dow <= 8'h00;
            o_dom <= 8'h00;
            o_mon <= 8'h00;
            o_year <= 8'h00;
            o_cent <= 8'h00;
        end else if (i_ce) begin
            if (i_step) begin
                o_sec <= s_nxt[7:0];
                if (s_nxt[8]) begin
                    o_min <= mi_nxt[7:0];
                    if (mi_nxt[8]) begin
                        o_hour <= h_nxt[7:0];
                        if (h_nxt[8]) begin
                            o_dow <= w_nxt[7:0];
                            o_dom <= d_nxt[7:0];
                            if (d_nxt[8]) begin
                                o_mon <= mo_nxt[7:0];
                                if (mo_nxt[8]) begin
                                    o_year <= y_nxt[7:0];
                                    if (y_nxt[8])
                                        o_cent <= c_nxt[7:0];
                                end
                            end
                        end
                    end
                end
            end else if (i_wr) begin
                case (i_idx)
                    `RTCC_IDX_SEC: o_sec <= i_wdata;
                    `RTCC_IDX_MIN: o_min <= i_wdata;
                    `RTCC_IDX_HOUR: o_hour <= i_wdata;
                    `RTCC_IDX_DOW: o_dow <= i_wdata;
                    `RTCC_IDX_DOM: o_dom <= i_wdata;
                    `RTCC_IDX_MON: o_mon <= i_wdata;
                    `RTCC_IDX_YEAR: o_year <= i_wdata;
                    `RTCC_IDX_CENT: o_cent <= i_wdata;
                    default: o_sec <= o_sec;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ### rtl/rtcc_regs.v
// Clock control, flags, divider, CMOS map and AXI4-Lite slave of the real-time clock
//
// Behaviour
// - Clear update inhibit lets seconds advance; setting it aborts and blocks updates.
// - Update inhibit, binary format, hour format survive main reset; read/write.
// - Periodic flag sets regardless of enable; enable gates irq; main reset clears enable.
// - Alarm flag on hours/minutes/seconds match, top bits 11 match anything.
// - Update-done enable cleared by main reset and by inhibit rising.
// - Binary format bit one counts binary, zero counts BCD.
// - Hour format bit one gives 24-hour, zero gives 12-hour.
// - Mode bits 0 and 3 read zero, writes ignored.
// - Request flag and low irq when any flag meets its enable.
// - Flag read returns snapshot, clears read ones, later events kept.
// - Enabling an already set flag asserts irq at once.
// - Periodic flag sets on falling edge of selected divider tap.
// - Update-done flag sets at end of each update.
// - Flag bits 3..0 and valid bit 6 read zero, writes ignored.
// - Valid bit cleared only by battery reset, set only by reading it.
// - Day alarm bits 5..0 writable anytime, read zero when disabled.
// - Century byte increments when year wraps to zero.
// - General storage bytes stay accessible during updates, battery retained.
// - Index 7F of each bank maps to the shared access register.
// - Divider gives one-second tick; first update half second after reset.
// - Periodic rate selectable from 500 ms down to 122.07 us.
// - Divider control: normal, held reset, oscillator off; codes 0, 4 and 5 also run normally.
// - Update-in-progress rises 244 us early, holds through 1948 us update.
// - Rate field picks one of 13 taps (codes 8 and 9 repeat 1 and 2), zero disables.
// - Update ripples seconds through century, then compares alarm bytes.
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_defines.vh"
module rtcc_regs #(
    parameter ADDR_W = 12,
    parameter DIV_STAGES = 22,
    parameter UPD_CYC = `RTCC_UPD_CYC
) (
    // Clock, resets, enable
    input wire i_clk,
    input wire i_rst_n,
    input wire i_bat_rst_n,
    input wire i_ce,
    // 32.768 kHz time base, one-cycle pulse
    input wire i_osc_tick,
    // AXI4-Lite write
    input wire [ADDR_W-1:0] i_awaddr,
    input wire i_awvalid,
    output reg o_awready,
    input wire [31:0] i_wdata,
    input wire [3:0] i_wstrb,
    input wire i_wvalid,
    output reg o_wready,
    output reg [1:0] o_bresp,
    output reg o_bvalid,
    input wire i_bready,
    // AXI4-Lite read
    input wire [ADDR_W-1:0] i_araddr,
    input wire i_arvalid,
    output reg o_arready,
    output reg [31:0] o_rdata,
    output reg [1:0] o_rresp,
    output reg o_rvalid,
    input wire i_rready,
    // Open-drain interrupt pin
    output reg o_irq_n,
    output reg o_irq_oe
);
    localparam integer UIP_AT_I = 32'h7FFF - `RTCC_UIP_LEAD_TICKS;
    localparam [14:0] UIP_AT = UIP_AT_I[14:0];
    localparam [19:0] UPD_LEN = UPD_CYC[19:0];

    function alm_hit;
        input [7:0] a;
        input [7:0] t;
        alm_hit = (a[7:6] == 2'h3) || (a == t);
    endfunction
    // rate span from taps
    // Mask of divider bits whose all-ones state precedes the tap's falling edge
    function [14:0] tap_mask;
        input [3:0] rs;
        reg [3:0] k;
        begin
            k = (rs == 4'h1) ? 4'h6 : (rs == 4'h2) ? 4'h7 : rs - 4'h2;
            tap_mask = (15'h0002 << k) - 15'h0001;
        end
    endfunction

    wire rst_main = !i_rst_n || !i_bat_rst_n;

    // Bus state
    reg aw_hold_r, w_hold_r, aw_err_r, ar_err_r, rd_pend_r, wb_r;
    reg [7:0] aw_idx_r, ar_idx_r, wd_r;
    // Control and status
    reg [3:0] rs_r;
    reg [2:0] dv_r;
    reg uip_r, set_r, pie_r, aie_r, uie_r, bin_r, h24_r;
    reg pf_r, af_r, uf_r, vrt_r;
    reg [5:0] dalm_r;
    reg [7:0] shr_r;
    reg [DIV_STAGES-1:0] div_r;
    reg [19:0] upd_cnt_r;
    reg step_r, chk_r;
    reg [7:0] ram [0:255];
    reg [7:0] rbyte;
    integer k;

    wire [7:0] sec, min, hour, dow, dom, mon, year, cent;

    wire wr_fire = aw_hold_r && w_hold_r && !o_bvalid;
    wire wr_en = wr_fire && !aw_err_r && wb_r;
    wire wr_mode = wr_en && (aw_idx_r == `RTCC_IDX_MODE);
    wire rd_ok = rd_pend_r && !ar_err_r;

    wire dv_held = (dv_r == 3'h1) || (dv_r[2:1] == 2'h3);
    wire dv_run = !dv_held && (dv_r != `RTCC_DV_OSC_OFF);
    wire tick_run = i_osc_tick && dv_run;

    // one-second boundary when bit 14 falls
    wire sec_ev = tick_run && (div_r[14:0] == 15'h7FFF);
    wire uip_ev = tick_run && !set_r && (div_r[14:0] == UIP_AT);
    wire pf_ev = tick_run && (rs_r != 4'h0)
        && ((div_r[14:0] & tap_mask(rs_r)) == tap_mask(rs_r));
    // nonzero day alarm counts as enabled
    wire dalm_en = (dalm_r != 6'h00);
    wire af_ev = chk_r && alm_hit(ram[`RTCC_IDX_SEC_ALM], sec)
        && alm_hit(ram[`RTCC_IDX_MIN_ALM], min)
        && alm_hit(ram[`RTCC_IDX_HOUR_ALM], hour)
        && (!dalm_en || ({2'h0, dalm_r} == dom));
    wire uf_ev = chk_r;
    // inhibit aborts at once, even in the writing cycle
    wire abort = set_r || (wr_mode && wd_r[`RTCC_MODE_SET]) || !dv_run;
    wire irq_request_flag = (pf_r && pie_r) || (af_r && aie_r) || (uf_r && uie_r);
    // clear only what the snapshot showed
    wire [2:0] clr = (rd_ok && ar_idx_r == `RTCC_IDX_FLAGS) ? {pf_r, af_r, uf_r} : 3'h0;

    rtcc_cal u_cal (
        .i_clk(i_clk),
        .i_bat_rst_n(i_bat_rst_n),
        .i_ce(i_ce),
        .i_wr(wr_en),
        .i_idx(aw_idx_r),
        .i_wdata(wd_r),
        .i_step(step_r),
        .i_bin(bin_r),
        .i_h24(h24_r),
        .o_sec(sec),
        .o_min(min),
        .o_hour(hour),
        .o_dow(dow),
        .o_dom(dom),
        .o_mon(mon),
        .o_year(year),
        .o_cent(cent)
    );

    always @* begin
        case (ar_idx_r)
            `RTCC_IDX_SEC: rbyte = sec;
            `RTCC_IDX_MIN: rbyte = min;
            `RTCC_IDX_HOUR: rbyte = hour;
            `RTCC_IDX_DOW: rbyte = dow;
            `RTCC_IDX_DOM: rbyte = dom;
            `RTCC_IDX_MON: rbyte = mon;
            `RTCC_IDX_YEAR: rbyte = year;
            `RTCC_IDX_RATE: rbyte = {uip_r, dv_r, rs_r};
            // bits 3 and 0 read zero
            `RTCC_IDX_MODE: rbyte = {set_r, pie_r, aie_r, uie_r, 1'b0, bin_r, h24_r, 1'b0};
            `RTCC_IDX_FLAGS: rbyte = {irq_request_flag, pf_r, af_r, uf_r, 4'h0};
            `RTCC_IDX_VALID: rbyte = {vrt_r, 1'b0, dalm_en ? dalm_r : 6'h00};
            `RTCC_IDX_CENT: rbyte = cent;
            // shared access register in both banks
            `RTCC_IDX_SHR0, `RTCC_IDX_SHR1: rbyte = shr_r;
            default: rbyte = ram[ar_idx_r];
        endcase
    end

    // Bus slave; one write and one read outstanding at most
    always @(posedge i_clk) begin
        if (rst_main) begin
            o_awready <= 1'b1;
            o_wready <= 1'b1;
            o_arready <= 1'b1;
            o_bvalid <= 1'b0;
            o_rvalid <= 1'b0;
            o_bresp <= `RTCC_RESP_OKAY;
            o_rresp <= `RTCC_RESP_OKAY;
            o_rdata <= 32'h0000_0000;
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            rd_pend_r <= 1'b0;
            aw_err_r <= 1'b0;
            ar_err_r <= 1'b0;
            wb_r <= 1'b0;
            aw_idx_r <= 8'h00;
            ar_idx_r <= 8'h00;
            wd_r <= 8'h00;
        end else if (i_ce) begin
            if (o_awready && i_awvalid) begin
                aw_hold_r <= 1'b1;
                o_awready <= 1'b0;
                aw_idx_r <= i_awaddr[9:2];
                aw_err_r <= |i_awaddr[ADDR_W-1:10];
            end
            if (o_wready && i_wvalid) begin
                w_hold_r <= 1'b1;
                o_wready <= 1'b0;
                wd_r <= i_wdata[7:0];
                wb_r <= i_wstrb[0];
            end
            if (wr_fire) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= aw_err_r ? `RTCC_RESP_SLVERR : `RTCC_RESP_OKAY;
            end
            if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
                o_awready <= 1'b1;
                o_wready <= 1'b1;
            end
            if (o_arready && i_arvalid) begin
                rd_pend_r <= 1'b1;
                o_arready <= 1'b0;
                ar_idx_r <= i_araddr[9:2];
                ar_err_r <= |i_araddr[ADDR_W-1:10];
            end
            if (rd_pend_r) begin
                rd_pend_r <= 1'b0;
                o_rvalid <= 1'b1;
                o_rdata <= ar_err_r ? 32'h0000_0000 : {24'h00_0000, rbyte};
                o_rresp <= ar_err_r ? `RTCC_RESP_SLVERR : `RTCC_RESP_OKAY;
            end
            if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
                o_arready <= 1'b1;
            end
        end
    end

    // Battery-backed state: format bits, divider, update sequencer
    always @(posedge i_clk) begin
        if (!i_bat_rst_n) begin
            rs_r <= 4'h0;
            dv_r <= `RTCC_DV_BAT_RST;
            set_r <= 1'b0;
            bin_r <= 1'b0;
            h24_r <= 1'b0;
            vrt_r <= 1'b0;
            dalm_r <= 6'h00;
            div_r <= `RTCC_DIV_RST;
            uip_r <= 1'b0;
            upd_cnt_r <= 20'h0_0000;
            step_r <= 1'b0;
            chk_r <= 1'b0;
        end else if (i_ce) begin
            // held divider restarts half a second from the boundary
            if (dv_held)
                div_r <= `RTCC_DIV_RST;
            else if (tick_run)
                div_r <= div_r + 1'b1;
            if (wr_en && aw_idx_r == `RTCC_IDX_RATE) begin
                dv_r <= wd_r[6:4];
                rs_r <= wd_r[3:0];
            end
            if (wr_mode) begin
                set_r <= wd_r[`RTCC_MODE_SET];
                bin_r <= wd_r[`RTCC_MODE_BIN];
                h24_r <= wd_r[`RTCC_MODE_H24];
            end
            if (wr_en && aw_idx_r == `RTCC_IDX_VALID)
                dalm_r <= wd_r[5:0];
            // software reads it once power is good
            if (rd_ok && ar_idx_r == `RTCC_IDX_VALID)
                vrt_r <= 1'b1;
            step_r <= 1'b0;
            chk_r <= step_r;
            // inhibit or stopped divider cancels the sequence
            if (abort) begin
                uip_r <= 1'b0;
                upd_cnt_r <= 20'h0_0000;
            end else if (upd_cnt_r != 20'h0_0000) begin
                upd_cnt_r <= upd_cnt_r - 20'h0_0001;
                // status falls as the update finishes
                if (upd_cnt_r == 20'h0_0001) begin
                    step_r <= 1'b1;
                    uip_r <= 1'b0;
                end
            end else if (sec_ev && uip_r) begin
                upd_cnt_r <= UPD_LEN;
            end else if (uip_ev) begin
                uip_r <= 1'b1;
            end
        end
    end

    // Main-supply state: enables, flags, shared register, irq pin
    always @(posedge i_clk) begin
        if (rst_main) begin
            pie_r <= 1'b0;
            aie_r <= 1'b0;
            uie_r <= 1'b0;
            pf_r <= 1'b0;
            af_r <= 1'b0;
            uf_r <= 1'b0;
            shr_r <= `RTCC_SHR_RST;
            o_irq_n <= 1'b1;
            o_irq_oe <= 1'b0;
        end else if (i_ce) begin
            if (wr_mode) begin
                pie_r <= wd_r[`RTCC_MODE_PIE];
                aie_r <= wd_r[`RTCC_MODE_AIE];
                // inhibit rising wins over the written enable
                uie_r <= wd_r[`RTCC_MODE_UIE] && !(wd_r[`RTCC_MODE_SET] && !set_r);
            end
            if (wr_en && (aw_idx_r == `RTCC_IDX_SHR0 || aw_idx_r == `RTCC_IDX_SHR1))
                shr_r <= {wd_r[7], 3'h0, wd_r[3:0]};
            // a new event in the clearing cycle stays set
            {pf_r, af_r, uf_r} <= ({pf_r, af_r, uf_r} & ~clr) | {pf_ev, af_ev, uf_ev};
            // level follows flags and enables, so late enables fire
            o_irq_n <= !irq_request_flag;
            o_irq_oe <= irq_request_flag;
        end
    end

    always @(posedge i_clk) begin
        if (!i_bat_rst_n) begin
            for (k = 0; k < 256; k = k + 1)
                ram[k] <= 8'h00;
        end else if (i_ce && wr_en) begin
            ram[aw_idx_r] <= wd_r;
        end
    end
endmodule
`default_nettype wire

// ### tb/rtcc_regs_monitor.sv
// Port-level checks of the clock control register block
`timescale 1ns/1ps
`default_nettype none
module rtcc_regs_monitor #(
    parameter ADDR_W = 12
) (
    // Clock and resets
    input wire i_clk,
    input wire i_rst_n,
    input wire i_bat_rst_n,
    // Bus
    input wire i_awvalid,
    input wire o_awready,
    input wire i_wvalid,
    input wire o_wready,
    input wire [1:0] o_bresp,
    input wire o_bvalid,
    input wire i_bready,
    input wire [ADDR_W-1:0] i_araddr,
    input wire i_arvalid,
    input wire o_arready,
    input wire [31:0] o_rdata,
    input wire [1:0] o_rresp,
    input wire o_rvalid,
    input wire i_rready,
    // Interrupt pin
    input wire o_irq_n,
    input wire o_irq_oe
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n || !i_bat_rst_n);
    sequence s_rd_taken;
        i_arvalid && o_arready;
    endsequence
    sequence s_wr_taken;
        i_awvalid && o_awready && i_wvalid && o_wready;
    endsequence
    a_irq_pin_pair: assert property (o_irq_oe == !o_irq_n)
        else $error("irq enable and level disagree");
    a_read_answer: assert property (s_rd_taken |=> ##1 o_rvalid && !o_arready)
        else $error("read answer late");
    a_read_snapshot: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data moved while pending");
    a_write_answer: assert property (s_wr_taken |=> ##1 o_bvalid && !o_awready && !o_wready)
        else $error("write answer late");
    a_write_holds: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped");
    a_bad_address: assert property (s_rd_taken ##0 (i_araddr[ADDR_W-1:10] != 0)
        |=> ##1 o_rresp == 2'h2 && o_rdata == 32'h0)
        else $error("bad address not refused");
    a_byte_only: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_reset_quiet: assert property (disable iff (1'b0)
        !i_rst_n |=> o_irq_n && !o_irq_oe && !o_bvalid && !o_rvalid)
        else $error("reset left outputs active");
endmodule
bind rtcc_regs rtcc_regs_monitor #(.ADDR_W(ADDR_W)) u_mon (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_bat_rst_n(i_bat_rst_n),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr),
    .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_rvalid(o_rvalid), .i_rready(i_rready), .o_irq_n(o_irq_n), .o_irq_oe(o_irq_oe)
);
`default_nettype wire

// ### tb/rtcc_tb_host.sv
// Time base and pulled-up interrupt line of the far side
`timescale 1ns/1ps
`default_nettype none
module rtcc_tb_host (
    // Clock
    input wire logic i_clk,
    // Interrupt pin
    input wire logic i_irq_oe,
    output wire logic o_irq_line,
    // Time base
    output logic o_osc_tick
);
    initial o_osc_tick = 1'b0;
    // Sped up so half a second fits the run
    always @(posedge i_clk) o_osc_tick <= !o_osc_tick;
    // Pull-up holds the line whenever the block lets go
    assign o_irq_line = i_irq_oe ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ### tb/tb_rtc_control_interrupt_regs.sv
// Self-checking bench for the clock control register block
`timescale 1ns/1ps
`default_nettype none
`include "rtcc_defines.vh"
module tb_rtc_control_interrupt_regs;
    localparam logic [7:0] MD = `RTCC_IDX_MODE;
    localparam logic [7:0] FL = `RTCC_IDX_FLAGS;
    localparam logic [7:0] VL = `RTCC_IDX_VALID;
    localparam logic [7:0] RT = `RTCC_IDX_RATE;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_bat_rst_n = 1'b0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire [31:0] rdata;
    wire [1:0] bresp, rresp;
    wire awready, wready, bvalid, arready, rvalid, irq_n, irq_oe, tick, irq_line;
    int num_errors = 0;
    int checks_done = 0;
    logic [31:0] seed = 32'h21;
    logic [7:0] t0 [10] = '{8'h3B, 8'hC0, 8'h3B, 8'hC0, 8'h17, 8'hC0, 8'h07, 8'h1F, 8'h0C, 8'h63};
    logic [7:0] t1 [10] = '{8'h00, 8'hC0, 8'h00, 8'hC0, 8'h00, 8'hC0, 8'h01, 8'h01, 8'h01, 8'h00};
    always #20 i_clk = !i_clk;
    rtcc_regs #(.UPD_CYC(20)) dut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_bat_rst_n(i_bat_rst_n), .i_ce(1'b1),
        .i_osc_tick(tick), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
        .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
        .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
        .o_rvalid(rvalid), .i_rready(rready), .o_irq_n(irq_n), .o_irq_oe(irq_oe));
    rtcc_tb_host u_host (.i_clk(i_clk), .i_irq_oe(irq_oe), .o_irq_line(irq_line),
        .o_osc_tick(tick));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Update-done enable drops when inhibit rises in the same write
    function automatic logic [7:0] exp_mode(input logic [7:0] w, input logic set_was);
        logic [7:0] e;
        e = w & 8'hF6;
        if (w[7] && !set_was) e[4] = 1'b0;
        return e;
    endfunction
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        // Edge between transfers keeps each strobe to one assignment per step
        @(posedge i_clk);
        awaddr <= {2'b00, i, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge i_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk("bresp", 32'(bresp), 32'(`RTCC_RESP_OKAY));
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge i_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge i_clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask
    task automatic rc(input logic [7:0] i, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd({2'b00, i, 2'b00}, d, r);
        chk($sformatf("reg %h", i), d, {24'h0, e});
    endtask
    task automatic complete_run;
        $display("Checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (50000) @(posedge i_clk);
        num_errors++;
        complete_run();
    end
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] v, m;
        int n;
        repeat (10) @(posedge i_clk);
        i_rst_n <= 1'b1;
        i_bat_rst_n <= 1'b1;
        @(posedge i_clk);
        // valid register read only once power is up
        rc(VL, 8'h00);
        rc(VL, 8'h80);
        rc(RT, 8'h30);
        rc(`RTCC_IDX_SHR1, 8'h80);
        wr(`RTCC_IDX_SHR0, 8'hFF);
        rc(`RTCC_IDX_SHR1, 8'h8F);
        m = 8'h00;
        for (int k = 0; k < 6; k++) begin
            seed = xs(seed);
            v = (k == 0) ? 8'h16 : (k == 1) ? 8'h96 : (k == 2) ? 8'h7F : seed[7:0];
            wr(MD, v);
            m = exp_mode(v, m[7]);
            rc(MD, m);
        end
        wr(MD, 8'h76);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        rc(MD, 8'h06);
        wr(FL, 8'hFF);
        rc(FL, 8'h00);
        wr(VL, 8'hD5);
        rc(VL, 8'h95);
        wr(VL, 8'h80);
        rc(VL, 8'h80);
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            v = 8'h0E + {3'b000, seed[12:8]};
            wr(v, seed[7:0]);
            rc(v, seed[7:0]);
        end
        rd(12'h400, d, r);
        chk("bad resp", 32'(r), 32'(`RTCC_RESP_SLVERR));
        wr(RT, 8'h23);
        repeat (20) @(posedge i_clk);
        chk("irq masked", 32'(irq_line), 32'h1);
        wr(MD, 8'hC6);
        repeat (2) @(posedge i_clk);
        chk("irq on enable", 32'(irq_line), 32'h0);
        wr(RT, 8'h20);
        rc(FL, 8'hC0);
        rc(FL, 8'h00);
        repeat (2) @(posedge i_clk);
        chk("irq released", 32'(irq_line), 32'h1);
        wr(MD, 8'h86);
        for (int k = 0; k < 10; k++) wr(k[7:0], t0[k]);
        wr(`RTCC_IDX_CENT, 8'h05);
        wr(RT, 8'h70);
        wr(MD, 8'h16);
        wr(RT, 8'h20);
        n = 0;
        while (irq_line && n < 40000) begin
            @(posedge i_clk);
            n++;
        end
        chk("first update", 32'(n > 32700 && n < 32900), 32'h1);
        for (int k = 0; k < 10; k++) rc(k[7:0], t1[k]);
        rc(`RTCC_IDX_CENT, 8'h06);
        rc(FL, 8'hB0);
        complete_run();
    end
endmodule
`default_nettype wire
